/* File: design/epiu_pkg.sv */
// Package with register map, field positions and encodings of the external pin interrupt unit
package epiu_pkg;
   // Register byte addresses on APB
   localparam logic [11:0] ADDR_SENSE_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_ENABLE_MASK = 12'h004;
   localparam logic [11:0] ADDR_FLAGS = 12'h008;
   localparam logic [11:0] ADDR_MASK_HIGH = 12'h00c;
   localparam logic [11:0] ADDR_MASK_LOW = 12'h010;
   localparam logic [11:0] ADDR_CPU_CTRL = 12'h014;
   localparam logic [11:0] ADDR_VECTOR = 12'h018;
   // Field positions
   localparam int EXT_BIT = 6;
   localparam int HIGH_BIT = 5;
   localparam int LOW_BIT = 4;
   localparam int FLAG_HIGH_BIT = 1;
   localparam int FLAG_LOW_BIT = 0;
   localparam int GIE_BIT = 0;
   // Writable masks and reset values
   localparam logic [7:0] ENABLE_WMASK = 8'h70;
   localparam logic [7:0] MASK_HIGH_WMASK = 8'h0f;
   localparam logic [7:0] SENSE_WMASK = 8'h03;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Interrupt vector addresses
   localparam logic [15:0] VEC_NONE = 16'h0000;
   localparam logic [15:0] VEC_EXT = 16'h0001;
   localparam logic [15:0] VEC_GROUP_LOW = 16'h0002;
   localparam logic [15:0] VEC_GROUP_HIGH = 16'h0003;
   // Sense modes
   typedef enum logic [1:0] {
      SENSE_LOW = 2'b00,
      SENSE_ANY = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_RISE = 2'b11
   } epiu_sense_t;
endpackage : epiu_pkg

/* File: design/epiu_top.sv */
// External pin interrupt unit: sense control, pin-change groups, flags and vectoring
// How it works
// - Inputs are taken from pin level whatever the pin direction, so writes can interrupt.
// - Group low requests when any masked input among bits 7:0 toggles.
// - Group high requests when any masked input among bits 11:8 toggles.
// - Pin-change detection is combinational on raw pins; flags and wake request still take it on a clock edge.
// - Low-level mode requests continuously while the pin stays low.
// - Edge detection uses the clocked, sampled pin and runs only with the clock.
// - Low-level wake request is registered from a term combinational on the raw pin.
// - Level must last through wake-up, else no interrupt is vectored.
// - Sense field 00 low, 01 any change, 10 falling, 11 rising.
// - Pin is sampled before edge detection; pulses over one clock are caught.
// - Enable bit 6 gates the pin interrupt together with the global flag.
// - Enable bits 5 and 4 gate groups high and low with the global flag.
// - Reserved bits of mask and flag registers read zero.
// - Flag bit 6 sets when pin activity produces a request.
// - Flags clear on service entry or on a written one.
// - Flag bit 6 reads zero while low-level sensing is selected.
// - Flag bits 1 and 0 set on group high and group low requests.
// - An input counts only with its mask bit and its group enable set.
// - A set, enabled flag with global flag set vectors execution.
// - Vectors are 0x0001 pin, 0x0002 group low, 0x0003 group high.
`timescale 1ns/10ps
// One pin-change group: toggle detection against the last sample, and the group flag
module epiu_change_group #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Pins and their enables
   input wire logic [WIDTH-1:0] pins,
   input wire logic [WIDTH-1:0] pin_mask,
   input wire logic group_enable,
   // Flag
   input wire logic clear,
   output logic event_now,
   output logic flag
);

   logic [WIDTH-1:0] pins_prev;
   logic [WIDTH-1:0] pin_enable;

   assign pin_enable = pin_mask & {WIDTH{group_enable}};

   // Raw pin against the last sample, so a toggle shows before any clock edge
   assign event_now = |((pins ^ pins_prev) & pin_enable);

   // Last sample of each pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_prev <= '0;
      end else if (clk_en) begin
         pins_prev <= pins;
      end
   end

   // Set beats clear, so a toggle during a write-one is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= 1'b0;
      end else if (clk_en) begin
         if (event_now) begin
            flag <= 1'b1;
         end else if (clear) begin
            flag <= 1'b0;
         end
      end
   end

endmodule : epiu_change_group

module epiu_top #(
   parameter int NUM_PINS = 12
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External pins
   input wire logic ext_irq_pin,
   input wire logic [NUM_PINS-1:0] pin_change_input,
   // Processor side
   input wire logic irq_ack,
   output logic irq_req,
   output logic [15:0] irq_vector,
   output logic wake_req
);

   logic [1:0] sense_select;
   logic [7:0] interrupt_enable_mask;
   logic [3:0] change_mask_high;
   logic [7:0] change_mask_low;
   logic global_ie;
   logic ext_pin_flag;
   logic group_high_flag;
   logic group_low_flag;
   logic ext_sync;
   logic ext_prev;
   logic ext_event;
   logic low_event;
   logic high_event;
   logic level_active;
   logic wr_strobe;
   logic rd_strobe;
   logic wr_flags;
   // Register write strobes
   logic wr_sense;
   logic wr_enable;
   logic wr_mask_high;
   logic wr_mask_low;
   logic wr_status;
   // Flag clears
   logic clear_ext;
   logic clear_low;
   logic clear_high;
   logic ack_ext;
   logic ack_low;
   logic ack_high;
   logic [15:0] next_vector;
   logic [31:0] next_rdata;
   logic addr_ok;

   assign wr_strobe = psel && penable && pwrite && clk_en;
   assign rd_strobe = psel && !penable && !pwrite;
   // One write strobe per writable register
   assign wr_flags = wr_strobe && (paddr == epiu_pkg::ADDR_FLAGS);
   assign wr_sense = wr_strobe && (paddr == epiu_pkg::ADDR_SENSE_CONTROL);
   assign wr_enable = wr_strobe && (paddr == epiu_pkg::ADDR_ENABLE_MASK);
   assign wr_mask_high = wr_strobe && (paddr == epiu_pkg::ADDR_MASK_HIGH);
   assign wr_mask_low = wr_strobe && (paddr == epiu_pkg::ADDR_MASK_LOW);
   assign wr_status = wr_strobe && (paddr == epiu_pkg::ADDR_CPU_CTRL);

   // A flag clears on service entry for its own vector or on a written one
   assign clear_ext = ack_ext || (wr_flags && pwdata[epiu_pkg::EXT_BIT]);
   assign clear_low = ack_low || (wr_flags && pwdata[epiu_pkg::FLAG_LOW_BIT]);
   assign clear_high = ack_high || (wr_flags && pwdata[epiu_pkg::FLAG_HIGH_BIT]);

   // Pins are read whatever their direction, so software can interrupt by writing them
   epiu_change_group #(
      .WIDTH(8)
   ) u_group_low (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .pins(pin_change_input[7:0]),
      .pin_mask(change_mask_low),
      .group_enable(interrupt_enable_mask[epiu_pkg::LOW_BIT]),
      .clear(clear_low),
      .event_now(low_event),
      .flag(group_low_flag)
   );

   // Group high has only four inputs
   epiu_change_group #(
      .WIDTH(4)
   ) u_group_high (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .pins(pin_change_input[11:8]),
      .pin_mask(change_mask_high),
      .group_enable(interrupt_enable_mask[epiu_pkg::HIGH_BIT]),
      .clear(clear_high),
      .event_now(high_event),
      .flag(group_high_flag)
   );

   // Level sense follows the raw pin; request and wake outputs take it only on an enabled clock
   assign level_active = (sense_select == epiu_pkg::SENSE_LOW) && !ext_irq_pin
                         && interrupt_enable_mask[epiu_pkg::EXT_BIT];

   // Edge detection on the sampled pin only
   always_comb begin
      case (epiu_pkg::epiu_sense_t'(sense_select))
         epiu_pkg::SENSE_ANY: begin
            ext_event = ext_sync ^ ext_prev;
         end
         epiu_pkg::SENSE_FALL: begin
            ext_event = ext_prev && !ext_sync;
         end
         epiu_pkg::SENSE_RISE: begin
            ext_event = !ext_prev && ext_sync;
         end
         default: begin
            ext_event = 1'b0;
         end
      endcase
   end

   // Acknowledge clears the flag of the vector currently presented
   assign ack_ext = irq_ack && (irq_vector == epiu_pkg::VEC_EXT);
   assign ack_low = irq_ack && (irq_vector == epiu_pkg::VEC_GROUP_LOW);
   assign ack_high = irq_ack && (irq_vector == epiu_pkg::VEC_GROUP_HIGH);

   // The pin is sampled once; edges are seen between two samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync <= 1'b1;
      end else if (clk_en) begin
         ext_sync <= ext_irq_pin;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev <= 1'b1;
      end else if (clk_en) begin
         ext_prev <= ext_sync;
      end
   end

   // Control registers, one process each; reserved bits are never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_select <= 2'b00;
      end else if (wr_sense) begin
         sense_select <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable_mask <= epiu_pkg::RESET_BYTE;
      end else if (wr_enable) begin
         interrupt_enable_mask <= pwdata[7:0] & epiu_pkg::ENABLE_WMASK;
      end
   end

   // Only inputs 11:8 exist in the high group
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_mask_high <= 4'h0;
      end else if (wr_mask_high) begin
         change_mask_high <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_mask_low <= epiu_pkg::RESET_BYTE;
      end else if (wr_mask_low) begin
         change_mask_low <= pwdata[7:0];
      end
   end

   // Global enable gates vectoring but not the flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_ie <= 1'b0;
      end else if (wr_status) begin
         global_ie <= pwdata[epiu_pkg::GIE_BIT];
      end
   end

   // Flags: a new event wins over a clear in the same cycle; global flag not consulted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_pin_flag <= 1'b0;
      end else if (clk_en) begin
         if (sense_select == epiu_pkg::SENSE_LOW) begin
            ext_pin_flag <= 1'b0;
         end else if (ext_event && interrupt_enable_mask[epiu_pkg::EXT_BIT]) begin
            ext_pin_flag <= 1'b1;
         end else if (clear_ext) begin
            ext_pin_flag <= 1'b0;
         end
      end
   end

   // Vector selection; lowest address has priority. Level sense vectors while the pin is held low,
   // so a level gone before wake-up completes yields no vector.
   always_comb begin
      next_vector = epiu_pkg::VEC_NONE;
      if (global_ie) begin
         if (level_active || (ext_pin_flag && interrupt_enable_mask[epiu_pkg::EXT_BIT])) begin
            next_vector = epiu_pkg::VEC_EXT;
         end else if (group_low_flag && interrupt_enable_mask[epiu_pkg::LOW_BIT]) begin
            next_vector = epiu_pkg::VEC_GROUP_LOW;
         end else if (group_high_flag && interrupt_enable_mask[epiu_pkg::HIGH_BIT]) begin
            next_vector = epiu_pkg::VEC_GROUP_HIGH;
         end
      end
   end

   // Vector and request move together so the pair never disagrees
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_vector <= epiu_pkg::VEC_NONE;
         irq_req <= 1'b0;
      end else if (clk_en) begin
         irq_vector <= next_vector;
         irq_req <= (next_vector != epiu_pkg::VEC_NONE);
      end
   end

   // Registered copy of the asynchronous wake term for the sleep controller;
   // it stays a level while the pin stays low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_req <= 1'b0;
      end else if (clk_en) begin
         wake_req <= level_active || low_event || high_event;
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         epiu_pkg::ADDR_SENSE_CONTROL: begin
            next_rdata[1:0] = sense_select;
         end
         epiu_pkg::ADDR_ENABLE_MASK: begin
            next_rdata[7:0] = interrupt_enable_mask;
         end
         epiu_pkg::ADDR_FLAGS: begin
            next_rdata[epiu_pkg::EXT_BIT] = ext_pin_flag;
            next_rdata[epiu_pkg::FLAG_HIGH_BIT] = group_high_flag;
            next_rdata[epiu_pkg::FLAG_LOW_BIT] = group_low_flag;
         end
         epiu_pkg::ADDR_MASK_HIGH: begin
            next_rdata[3:0] = change_mask_high;
         end
         epiu_pkg::ADDR_MASK_LOW: begin
            next_rdata[7:0] = change_mask_low;
         end
         epiu_pkg::ADDR_CPU_CTRL: begin
            next_rdata[epiu_pkg::GIE_BIT] = global_ie;
         end
         epiu_pkg::ADDR_VECTOR: begin
            next_rdata[15:0] = irq_vector;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // APB answer: ready in the access phase, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // Read data is taken in the setup phase and held until the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && rd_strobe) begin
         prdata <= next_rdata;
      end
   end

endmodule : epiu_top

/* File: dv/epiu_pin_model.sv */
// Outside circuitry driving the interrupt and pin-change pins
`timescale 1ns/10ps
module epiu_pin_model (
   // Clock
   input wire logic pclk,
   // Levels asked for by the bench
   input wire logic want_ext,
   input wire logic [11:0] want_pc,
   // Pins
   output logic ext_irq_pin,
   output logic [11:0] pin_change_input
);
   // Pins move only on edges and hold whole cycles, so no pulse is under one clock
   initial begin
      ext_irq_pin = 1'b1;
      pin_change_input = 12'h000;
   end
   always @(posedge pclk) begin
      ext_irq_pin <= want_ext;
      pin_change_input <= want_pc;
   end
endmodule : epiu_pin_model

/* File: dv/epiu_top_checker.sv */
// Port checker for the external pin interrupt unit
`timescale 1ns/10ps
module epiu_top_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Processor side
   input wire logic irq_req,
   input wire logic [15:0] irq_vector
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_setup_answer: assert property (s_setup |=> s_answer)
      else $error("bus answer not one cycle after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read gave data");
   a_read_data: assert property ($changed(prdata) |-> pready && !pwrite)
      else $error("read data moved outside a read");
   a_vec_range: assert property (irq_req |-> irq_vector inside {16'h1, 16'h2, 16'h3})
      else $error("request with bad vector");
   a_vec_idle: assert property (!irq_req |-> irq_vector == 16'h0)
      else $error("vector without request");
   a_reset_quiet: assert property ($rose(presetn) |-> !irq_req && !pready)
      else $error("outputs active after reset");
endmodule : epiu_top_checker
bind epiu_top epiu_top_checker u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_req(irq_req), .irq_vector(irq_vector));

/* File: dv/test_external_pin_interrupt_unit.sv */
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/10ps
module test_external_pin_interrupt_unit;
   logic pclk, presetn, psel, penable, pwrite, irq_ack, irq_req, pready, pslverr, wake_req, want_ext, ext_pin, err;
   logic clk_en;
   logic [11:0] paddr, want_pc, pc_pins;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] irq_vector;
   int n_fail, n_tests;
   // Address, written, read back, refused
   typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} epiu_row_t;
   epiu_row_t rows [8] = '{'{epiu_pkg::ADDR_SENSE_CONTROL, '1, 32'h3, 0},
      '{epiu_pkg::ADDR_ENABLE_MASK, '1, 32'h70, 0}, '{epiu_pkg::ADDR_FLAGS, '1, 32'h0, 0},
      '{epiu_pkg::ADDR_MASK_HIGH, '1, 32'hf, 0}, '{epiu_pkg::ADDR_MASK_LOW, '1, 32'hff, 0},
      '{epiu_pkg::ADDR_CPU_CTRL, '1, 32'h1, 0}, '{epiu_pkg::ADDR_VECTOR, '1, 32'h0, 0},
      '{12'h01c, '1, 32'h0, 1}};
   epiu_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_irq_pin(ext_pin), .pin_change_input(pc_pins), .irq_ack(irq_ack),
      .irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req));
   epiu_pin_model u_pins (.pclk(pclk), .want_ext(want_ext), .want_pc(want_pc),
      .ext_irq_pin(ext_pin), .pin_change_input(pc_pins));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input int i, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= rows[i].a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      chk("bus answer", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge so the next call never re-drives psel in this time step
      @(posedge pclk);
   endtask : apb
   task automatic wirq(input logic v);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (irq_req !== v && k < 20);
      chk("irq request", {31'h0, v}, {31'h0, irq_req});
   endtask : wirq
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (6000) @(posedge pclk);
      n_fail++;
      conclude();
   end
   initial begin
      {presetn, psel, penable, pwrite, irq_ack, paddr, pwdata, want_pc} = '0;
      want_ext = 1'b1;
      clk_en = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(1'b0, i, 32'h0);
         chk("reset value", 32'h0, rd);
         apb(1'b1, i, rows[i].w);
         apb(1'b0, i, 32'h0);
         chk("read back", rows[i].r, rd);
         chk("refusal", {31'h0, rows[i].e}, {31'h0, err});
      end
      foreach (rows[i]) apb(1'b1, i, 32'h0);
      for (int g = 0; g < 2; g++) begin
         apb(1'b1, 4 - g, 32'h1);
         apb(1'b1, 1, g ? 32'h20 : 32'h10);
         want_pc <= g ? 12'h200 : 12'h002;
         repeat (4) @(posedge pclk);
         apb(1'b0, 2, 32'h0);
         chk("unmasked pin flag", 32'h0, rd);
         want_pc <= g ? 12'h300 : 12'h003;
         repeat (4) @(posedge pclk);
         apb(1'b0, 2, 32'h0);
         chk("group flag", g ? 32'h2 : 32'h1, rd);
         chk("request without global", 32'h0, {31'h0, irq_req});
         apb(1'b1, 5, 32'h1);
         wirq(1'b1);
         chk("group vector", g ? 32'h3 : 32'h2, {16'h0, irq_vector});
         irq_ack <= 1'b1;
         @(posedge pclk);
         irq_ack <= 1'b0;
         repeat (3) @(posedge pclk);
         apb(1'b0, 2, 32'h0);
         chk("flag after service", 32'h0, rd);
         apb(1'b1, 5, 32'h0);
         apb(1'b1, 1, 32'h0);
      end
      apb(1'b1, 1, 32'h40);
      for (int m = 1; m < 4; m++) begin
         apb(1'b1, 0, m);
         want_ext <= 1'b0;
         repeat (4) @(posedge pclk);
         apb(1'b0, 2, 32'h0);
         chk("falling flag", m != 3 ? 32'h40 : 32'h0, rd);
         apb(1'b1, 2, 32'h40);
         want_ext <= 1'b1;
         repeat (4) @(posedge pclk);
         apb(1'b0, 2, 32'h0);
         chk("rising flag", m != 2 ? 32'h40 : 32'h0, rd);
         apb(1'b1, 2, 32'h40);
         apb(1'b0, 2, 32'h0);
         chk("flag write one", 32'h0, rd);
      end
      apb(1'b1, 0, 32'h0);
      apb(1'b1, 5, 32'h1);
      want_ext <= 1'b0;
      wirq(1'b1);
      chk("level vector", 32'h1, {16'h0, irq_vector});
      chk("level wake", 32'h1, {31'h0, wake_req});
      apb(1'b0, 2, 32'h0);
      chk("level flag", 32'h0, rd);
      chk("level held", 32'h1, {31'h0, irq_req});
      want_ext <= 1'b1;
      wirq(1'b0);
      // A low clock enable freezes the request; it shows once the enable returns
      clk_en <= 1'b0;
      want_ext <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("frozen request", 32'h0, {31'h0, irq_req});
      clk_en <= 1'b1;
      wirq(1'b1);
      want_ext <= 1'b1;
      wirq(1'b0);
      // Reset in mid-run clears registers and outputs
      apb(1'b1, 0, 32'h3);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("reset request", 32'h0, {31'h0, irq_req});
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 0, 32'h0);
      chk("reset again", 32'h0, rd);
      conclude();
   end
endmodule : test_external_pin_interrupt_unit
